// ### rtl/usc_pkg.sv
// usc_pkg: register map, field positions, reset values and modes of the
// serial transceiver control block.
// assumes byte addresses on a 32-bit classic wishbone bus.
package usc_pkg;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_TXDATA   = 8'h00;
  localparam logic [7:0] OFS_RXDATA   = 8'h04;
  localparam logic [7:0] OFS_BAUD     = 8'h08;
  localparam logic [7:0] OFS_DIR      = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h14;
  localparam logic [7:0] OFS_RCSC     = 8'h18;
  localparam logic [7:0] OFS_IRQ_CLR  = 8'h20;
  localparam logic [7:0] OFS_TXSC     = 8'h98;
  // ----------------------------------------------------------------
  // transmit_status_control fields
  // ----------------------------------------------------------------
  localparam int TX_CLOCK_SOURCE_SELECT = 7;
  localparam int TX_9    = 6;
  localparam int TX_EN   = 5;
  localparam int TX_SYNC = 4;
  localparam int TX_HIGH_SPEED_BAUD_SELECT = 2;
  localparam int TX_SHIFT_REG_EMPTY_FLAG = 1;
  localparam int TX_9D   = 0;
  localparam logic [7:0] TXSC_WMASK = 8'hF5;
  // ----------------------------------------------------------------
  // receive_status_control fields
  // ----------------------------------------------------------------
  localparam int RC_SERIAL_PORT_ENABLE  = 7;
  localparam int RC_9     = 6;
  localparam int RC_SINGLE_RECEIVE_ENABLE  = 5;
  localparam int RC_CONTINUOUS_RECEIVE_ENABLE  = 4;
  localparam int RC_ADDRESS_DETECT_ENABLE = 3;
  localparam int RC_FRAMING_ERROR_FLAG  = 2;
  localparam int RC_OVERRUN_ERROR_FLAG  = 1;
  localparam int RC_9D    = 0;
  localparam logic [7:0] RCSC_WMASK = 8'hF8;
  // ----------------------------------------------------------------
  // port direction, interrupts, reset values
  // ----------------------------------------------------------------
  localparam int DIR_LO = 6;
  localparam int DIR_HI = 7;
  localparam logic [1:0] DIR_RST = 2'h3;
  localparam int IRQ_RX   = 0;
  localparam int IRQ_TX   = 1;
  localparam int IRQ_FRAMING_ERROR_FLAG = 2;
  localparam int IRQ_OVERRUN_ERROR_FLAG = 3;
  localparam int IRQ_W    = 4;
  // ----------------------------------------------------------------
  // timing: baud prescale per quarter bit, frame lengths
  // ----------------------------------------------------------------
  localparam logic [3:0] PRE_SYNC = 4'h0;
  localparam logic [3:0] PRE_HIGH = 4'h3;
  localparam logic [3:0] PRE_LOW  = 4'hF;
  localparam logic [3:0] BITS_8   = 4'h8;
  localparam logic [3:0] BITS_9   = 4'h9;
  localparam logic [1:0] Q_LAST   = 2'h3;
  localparam logic [1:0] Q_RISE   = 2'h1;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} usc_rx_t;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} usc_tx_t;
endpackage : usc_pkg

// ### rtl/usc_baud_gen.sv
// usc_baud_gen: free-running baud timer giving one tick per quarter bit.
// assumes divisor and prescale are stable except across a restart.
`timescale 1ns/1ns
module usc_baud_gen #(
  parameter int unsigned CNT_W = 8
) (
  input  wire logic             core_clk,    // system clock
  input  wire logic             reset,       // sync reset, high
  input  wire logic             clkEn,       // freezes state when low
  input  wire logic             restart,     // clears the timer
  input  wire logic [CNT_W-1:0] divisor,     // counter terminal count
  input  wire logic [3:0]       preMax,      // prescale terminal count
  output logic                  quarterTick  // one-cycle tick
);
  if (CNT_W < 2 || CNT_W > 16) begin : gBadWidth
    $error("usc_baud_gen: CNT_W out of range");
  end
  typedef struct packed {
    logic [3:0]       pre;
    logic [CNT_W-1:0] cnt;
    logic             tick;
  } usc_bg_t;
  usc_bg_t s;
  usc_bg_t n;
  always_comb begin
    n = s;
    n.tick = 1'b0;
    if (restart) begin
      n.pre = '0;
      n.cnt = '0;
    end else if (s.pre >= preMax) begin
      n.pre = '0;
      if (s.cnt == divisor) begin
        n.cnt  = '0;
        n.tick = 1'b1;
      end else begin
        n.cnt = s.cnt + 1'b1;
      end
    end else begin
      n.pre = s.pre + 4'h1;
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      s <= '0;
    end else if (clkEn) begin
      s <= n;
    end
  end
  assign quarterTick = s.tick;
endmodule : usc_baud_gen

// ### rtl/usc_majority.sv
// usc_majority: three-sample majority vote on the receive line.
// assumes lineIn is already synchronised to core_clk.
`timescale 1ns/1ns
module usc_majority (
  input  wire logic core_clk,  // system clock
  input  wire logic reset,     // sync reset, high
  input  wire logic clkEn,     // freezes state when low
  input  wire logic sampleEn,  // take one sample
  input  wire logic lineIn,    // synchronised line
  output logic      vote       // majority of last three samples
);
  typedef struct packed {
    logic [1:0] hist;
    logic       vote;
  } usc_mj_t;
  usc_mj_t s;
  usc_mj_t n;
  function automatic logic maj3(input logic a, input logic b, input logic c);
    return (a & b) | (a & c) | (b & c);
  endfunction : maj3
  always_comb begin
    n = s;
    if (sampleEn) begin
      n.vote = maj3(s.hist[1], s.hist[0], lineIn);
      n.hist = {s.hist[0], lineIn};
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      s <= '1;
    end else if (clkEn) begin
      s <= n;
    end
  end
  assign vote = s.vote;
endmodule : usc_majority

// ### rtl/usc_top.sv
// usc_top: serial transceiver control/status block with wishbone slave,
// async full-duplex and sync half-duplex master/slave operation.
// assumes pin inputs are asynchronous; the pad combines out/oe/in.
`timescale 1ns/1ns
// Overview of operation
// - pins serve only with enable and directions set
// - async mode: transmit and receive run independently
// - sync half duplex, master or slave
// - ninth bit marks address frames
// - clock source: master internal, slave external
// - mode bit: one sync, zero async
// - transmit enable bit gates the transmitter
// - high-speed select only matters in async
// - shift-empty flag read-only, resets to one
// - ninth bits: rx status, tx control
// - address detect: load only ninth-bit-one frames
// - framing flag updated with each loaded byte
// - overrun flag cleared by clearing continuous enable
// - baud write restarts the baud timer
// - divide by 64, 16 or 4 times divisor+1
// - async receive: three samples per bit, majority vote
module usc_top
  import usc_pkg::*;
(
  input  wire logic        core_clk, // system clock
  input  wire logic        reset,    // sync reset, high
  input  wire logic        clkEn,    // freezes state when low
  input  wire logic        cyc_i,    // wishbone cycle
  input  wire logic        stb_i,    // wishbone strobe
  input  wire logic        we_i,     // wishbone write
  input  wire logic [7:0]  adr_i,    // wishbone byte address
  input  wire logic [3:0]  sel_i,    // wishbone byte selects
  input  wire logic [31:0] dat_i,    // wishbone write data
  output logic      [31:0] dat_o,    // wishbone read data
  output logic             ack_o,    // wishbone acknowledge
  input  wire logic        txCkIn,   // tx/clock pin in
  output logic             txCkOut,  // tx/clock pin out
  output logic             txCkOe,   // tx/clock pin drive enable
  input  wire logic        rxDtIn,   // rx/data pin in
  output logic             rxDtOut,  // rx/data pin out
  output logic             rxDtOe,   // rx/data pin drive enable
  output logic             irq       // level interrupt
);
  import usc_pkg::*;
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic          ack;
    logic [31:0]   datOut;
    logic [7:0]    txCtl;
    logic [7:0]    rxCtl;
    logic [7:0]    baud;
    logic [1:0]    dir;
    logic [IRQ_W-1:0] irqStat;
    logic [IRQ_W-1:0] irqEn;
    logic          shift_reg_empty_flag;
    logic [8:0]    transmit_shift_register;
    usc_tx_t       txState;
    logic [3:0]    txBit;
    logic [1:0]    ph;
    logic          txLine;
    usc_rx_t       rxState;
    logic [3:0]    rxBit;
    logic [1:0]    rxQ;
    logic [8:0]    receive_shift_register;
    logic [7:0]    rxBuf;
    logic          rx_ninth_bit;
    logic          framing_error_flag;
    logic          overrun_error_flag;
    logic          rxFull;
    logic          rxMeta;
    logic          rxSync;
    logic          ckMeta;
    logic          ckSync;
    logic          ckPrev;
    logic          txCkO;
    logic          txCkE;
    logic          dtO;
    logic          dtE;
  } usc_state_t;
  usc_state_t s;
  usc_state_t n;
  // ----------------------------------------------------------------
  // decode of mode and bus
  // ----------------------------------------------------------------
  logic       syncMode;
  logic       master;
  logic       serial_port_enable;
  logic       pinsOn;
  logic       rxReq;
  logic       rxOn;
  logic       txGo;
  logic [3:0] txBits;
  logic [3:0] rxBits;
  logic [3:0] preMax;
  logic       qt;
  logic       vote;
  logic       ckFall;
  logic       ckRise;
  logic       txShift;
  logic       rxSyncSample;
  logic       req;
  logic       acc;
  logic       wr;
  logic       rd;
  logic       txLoad;
  logic       rdBuf;
  logic       baudWr;
  logic [IRQ_W-1:0] irqClr;
  logic [IRQ_W-1:0] evt;
  logic       done;
  logic       frameErr;
  logic       addrSkip;
  logic [31:0] rdData;

  assign syncMode = s.txCtl[TX_SYNC];
  assign master   = s.txCtl[TX_CLOCK_SOURCE_SELECT];
  assign serial_port_enable     = s.rxCtl[RC_SERIAL_PORT_ENABLE];
  assign pinsOn   = serial_port_enable & s.dir[DIR_HI] & s.dir[DIR_LO];
  assign rxReq    = s.rxCtl[RC_CONTINUOUS_RECEIVE_ENABLE] | (syncMode & s.rxCtl[RC_SINGLE_RECEIVE_ENABLE]);
  assign rxOn     = serial_port_enable & rxReq & ~s.overrun_error_flag;
  assign txGo     = serial_port_enable & s.txCtl[TX_EN] & ~(syncMode & rxReq);
  assign txBits   = s.txCtl[TX_9] ? BITS_9 : BITS_8;
  assign rxBits   = s.rxCtl[RC_9] ? BITS_9 : BITS_8;
  assign preMax   = syncMode ? PRE_SYNC :
                    (s.txCtl[TX_HIGH_SPEED_BAUD_SELECT] ? PRE_HIGH : PRE_LOW);
  assign ckFall   = s.ckPrev & ~s.ckSync;
  assign ckRise   = ~s.ckPrev & s.ckSync;
  // slave shifts on the external clock, master on its own phase
  assign txShift  = (syncMode & ~master) ? ckFall : (qt & s.ph == Q_LAST);
  assign rxSyncSample = master ? (qt & s.ph == Q_RISE) : ckRise;
  assign req      = cyc_i & stb_i & ~s.ack;
  assign acc      = cyc_i & stb_i & s.ack;
  assign wr       = acc & we_i & sel_i[0];
  assign rd       = acc & ~we_i;
  assign txLoad   = wr & adr_i == OFS_TXDATA & s.shift_reg_empty_flag & txGo;
  assign rdBuf    = rd & adr_i == OFS_RXDATA;
  assign baudWr   = wr & adr_i == OFS_BAUD;
  assign irqClr   = (wr & adr_i == OFS_IRQ_CLR) ? dat_i[IRQ_W-1:0] : '0;

  // ----------------------------------------------------------------
  // baud timer and receive line vote
  // ----------------------------------------------------------------
  usc_baud_gen #(.CNT_W(8)) uBaud (
    .core_clk    (core_clk),
    .reset       (reset),
    .clkEn       (clkEn),
    .restart     (baudWr),
    .divisor     (s.baud),
    .preMax      (preMax),
    .quarterTick (qt)
  );

  usc_majority uVote (
    .core_clk (core_clk),
    .reset    (reset),
    .clkEn    (clkEn),
    .sampleEn (qt & ~syncMode & (s.rxState == RX_IDLE | s.rxQ != Q_LAST)),
    .lineIn   (s.rxSync),
    .vote     (vote)
  );

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    rdData = '0;
    case (adr_i)
      OFS_TXSC: begin
        rdData[7:0]     = s.txCtl;
        rdData[TX_SHIFT_REG_EMPTY_FLAG] = s.shift_reg_empty_flag;
      end
      OFS_RCSC: begin
        rdData[7:0]     = s.rxCtl;
        rdData[RC_FRAMING_ERROR_FLAG] = s.framing_error_flag;
        rdData[RC_OVERRUN_ERROR_FLAG] = s.overrun_error_flag;
        rdData[RC_9D]   = s.rx_ninth_bit;
      end
      OFS_RXDATA:   rdData[7:0] = s.rxBuf;
      OFS_BAUD:     rdData[7:0] = s.baud;
      OFS_DIR:      rdData[DIR_HI:DIR_LO] = s.dir;
      OFS_IRQ_STAT: rdData[IRQ_W-1:0] = s.irqStat;
      OFS_IRQ_EN:   rdData[IRQ_W-1:0] = s.irqEn;
      default:      rdData = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    n = s;
    evt = '0;
    done = 1'b0;
    frameErr = 1'b0;
    addrSkip = 1'b0;
    n.ack = req;
    n.rxMeta = rxDtIn;
    n.rxSync = s.rxMeta;
    n.ckMeta = txCkIn;
    n.ckSync = s.ckMeta;
    n.ckPrev = s.ckSync;
    if (req) begin
      n.datOut = rdData;
    end
    if (wr) begin
      case (adr_i)
        OFS_TXSC:   n.txCtl = dat_i[7:0] & TXSC_WMASK;
        OFS_RCSC:   n.rxCtl = dat_i[7:0] & RCSC_WMASK;
        OFS_BAUD:   n.baud = dat_i[7:0];
        OFS_DIR:    n.dir = dat_i[DIR_HI:DIR_LO];
        OFS_IRQ_EN: n.irqEn = dat_i[IRQ_W-1:0];
        default:    n.baud = s.baud;
      endcase
    end
    if (rdBuf) begin
      n.rxFull = 1'b0;
    end
    if (~n.rxCtl[RC_CONTINUOUS_RECEIVE_ENABLE]) begin
      n.overrun_error_flag = 1'b0;
    end
    if (qt) begin
      n.ph = s.ph + 2'h1;
    end
    // transmitter
    if (s.txState == TX_IDLE) begin
      if (txLoad) begin
        n.transmit_shift_register = {s.txCtl[TX_9D], dat_i[7:0]};
        n.shift_reg_empty_flag = 1'b0;
        n.ph = '0;
        n.txBit = '0;
        n.txState = syncMode ? TX_DATA : TX_START;
        n.txLine = syncMode & dat_i[0];
      end
    end else if (~serial_port_enable | ~s.txCtl[TX_EN]) begin
      n.txState = TX_IDLE;
      n.shift_reg_empty_flag = 1'b1;
      n.txLine = 1'b1;
    end else if (txShift) begin
      unique case (s.txState)
        TX_START: begin
          n.txState = TX_DATA;
          n.txLine = s.transmit_shift_register[0];
        end
        TX_DATA: begin
          if (s.txBit == txBits - 4'h1) begin
            n.txLine = 1'b1;
            if (syncMode) begin
              n.txState = TX_IDLE;
              n.shift_reg_empty_flag = 1'b1;
              evt[IRQ_TX] = 1'b1;
            end else begin
              n.txState = TX_STOP;
            end
          end else begin
            n.txBit = s.txBit + 4'h1;
            n.txLine = s.transmit_shift_register[s.txBit + 4'h1];
          end
        end
        TX_STOP: begin
          n.txState = TX_IDLE;
          n.shift_reg_empty_flag = 1'b1;
          evt[IRQ_TX] = 1'b1;
        end
        TX_IDLE: n.txState = TX_IDLE;
      endcase
    end
    // receiver
    if (qt & s.rxState != RX_IDLE) begin
      n.rxQ = s.rxQ + 2'h1;
    end
    if (~rxOn) begin
      n.rxState = RX_IDLE;
    end else begin
      unique case (s.rxState)
        RX_IDLE: begin
          if (syncMode) begin
            n.rxState = RX_DATA;
            n.rxBit = '0;
            n.ph = '0;
          end else if (qt & ~s.rxSync) begin
            n.rxState = RX_START;
            n.rxQ = 2'h1;
          end
        end
        RX_START: begin
          if (qt & s.rxQ == Q_LAST) begin
            n.rxState = vote ? RX_IDLE : RX_DATA;
            n.rxBit = '0;
          end
        end
        RX_DATA: begin
          if (syncMode ? rxSyncSample : (qt & s.rxQ == Q_LAST)) begin
            n.receive_shift_register[s.rxBit] = syncMode ? s.rxSync : vote;
            if (s.rxBit == rxBits - 4'h1) begin
              n.rxBit = '0;
              if (syncMode) begin
                done = 1'b1;
              end else begin
                n.rxState = RX_STOP;
              end
            end else begin
              n.rxBit = s.rxBit + 4'h1;
            end
          end
        end
        RX_STOP: begin
          if (qt & s.rxQ == Q_LAST) begin
            done = 1'b1;
            frameErr = ~vote;
            n.rxState = RX_IDLE;
          end
        end
      endcase
    end
    if (done) begin
      addrSkip = ~syncMode & s.rxCtl[RC_9] & s.rxCtl[RC_ADDRESS_DETECT_ENABLE] & ~n.receive_shift_register[8];
      if (!addrSkip) begin
        if (s.rxFull & ~rdBuf) begin
          n.overrun_error_flag = 1'b1;
          evt[IRQ_OVERRUN_ERROR_FLAG] = 1'b1;
        end else begin
          n.rxBuf = n.receive_shift_register[7:0];
          n.rx_ninth_bit = s.rxCtl[RC_9] & n.receive_shift_register[8];
          n.framing_error_flag = frameErr;
          n.rxFull = 1'b1;
          evt[IRQ_RX] = 1'b1;
          evt[IRQ_FRAMING_ERROR_FLAG] = frameErr;
        end
      end
      if (syncMode & ~n.rxCtl[RC_CONTINUOUS_RECEIVE_ENABLE]) begin
        n.rxCtl[RC_SINGLE_RECEIVE_ENABLE] = 1'b0;
      end
    end
    n.irqStat = (s.irqStat & ~irqClr) | evt;
    // pins
    n.txCkE = pinsOn & ~(syncMode & ~master);
    n.txCkO = syncMode ? (master & n.ph[1] &
              (n.txState != TX_IDLE | n.rxState != RX_IDLE)) : n.txLine;
    n.dtE = pinsOn & syncMode & n.txState != TX_IDLE;
    n.dtO = n.txLine;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      s <= '0;
      s.shift_reg_empty_flag <= 1'b1;
      s.dir <= DIR_RST;
      s.txLine <= 1'b1;
      s.rxMeta <= 1'b1;
      s.rxSync <= 1'b1;
      s.ckMeta <= 1'b1;
      s.ckSync <= 1'b1;
      s.ckPrev <= 1'b1;
      s.txState <= TX_IDLE;
      s.rxState <= RX_IDLE;
    end else if (clkEn) begin
      s <= n;
    end
  end

  assign dat_o   = s.datOut;
  assign ack_o   = s.ack;
  assign txCkOut = s.txCkO;
  assign txCkOe  = s.txCkE;
  assign rxDtOut = s.dtO;
  assign rxDtOe  = s.dtE;
  assign irq     = |(s.irqStat & s.irqEn);
endmodule : usc_top

// ### dv/usc_top_assertions.sv
// usc_top_assertions: port-level checks of usc_top.
// assumes a master that holds each request until its ack.
`timescale 1ns/1ns
module usc_top_assertions
  import usc_pkg::*;
(
  input wire logic        core_clk, // clock
  input wire logic        reset,    // sync reset
  input wire logic        cyc_i,    // cycle
  input wire logic        stb_i,    // strobe
  input wire logic        we_i,     // write
  input wire logic [7:0]  adr_i,    // address
  input wire logic [3:0]  sel_i,    // selects
  input wire logic [31:0] dat_i,    // write data
  input wire logic [31:0] dat_o,    // read data
  input wire logic        ack_o,    // ack
  input wire logic        txCkOe,   // clock pin oe
  input wire logic        rxDtOe,   // data pin oe
  input wire logic        irq       // interrupt
);
  logic [7:0] txM, rcM;
  logic [3:0] enM;
  logic [1:0] dirM;
  logic       pOn;
  assign pOn = rcM[RC_SERIAL_PORT_ENABLE] && dirM == 2'h3;
  // mirrors of the writable control fields, all but the baud divisor and the self-clearing single receive enable
  always_ff @(posedge core_clk) begin
    if (reset) begin
      txM  <= 8'h00;
      rcM  <= 8'h00;
      enM  <= 4'h0;
      dirM <= DIR_RST;
    end else if (ack_o && we_i && sel_i[0]) begin
      if (adr_i == OFS_TXSC) txM <= dat_i[7:0] & TXSC_WMASK;
      if (adr_i == OFS_RCSC) rcM <= dat_i[7:0] & 8'hD8;
      if (adr_i == OFS_IRQ_EN) enM <= dat_i[3:0];
      if (adr_i == OFS_DIR) dirM <= dat_i[DIR_HI:DIR_LO];
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  chk_ack_once: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  chk_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not acked next cycle");
  chk_pin_gate: assert property (
    !$past(reset) |-> txCkOe == $past(pOn && !(txM[TX_SYNC] && !txM[TX_CLOCK_SOURCE_SELECT]))
      && (!rxDtOe || $past(pOn))) else $error("pin drive enable wrong");
  chk_dt_quiet: assert property (
    !$past(reset) && $past(!txM[TX_SYNC] || rcM[RC_CONTINUOUS_RECEIVE_ENABLE]) |-> !rxDtOe)
    else $error("data pin driven outside sync transmit");
  chk_irq_mask: assert property (enM == 4'h0 |-> !irq)
    else $error("interrupt with all sources masked");
  chk_dat_upper: assert property (ack_o |-> dat_o[31:8] == 24'h0)
    else $error("upper read data not zero");
  chk_txsc_back: assert property (
    ack_o && $past(!we_i && adr_i == OFS_TXSC) |-> (dat_o[7:0] & 8'hFD) == txM)
    else $error("transmit control readback wrong");
  chk_rcsc_back: assert property (
    ack_o && $past(!we_i && adr_i == OFS_RCSC) |-> (dat_o[7:0] & 8'hD8) == rcM)
    else $error("receive control readback wrong");
endmodule : usc_top_assertions
bind usc_top usc_top_assertions u_chk (.core_clk(core_clk), .reset(reset),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
  .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .txCkOe(txCkOe),
  .rxDtOe(rxDtOe), .irq(irq));

// ### dv/usc_peer.sv
// usc_peer: async terminal on the far side of the serial pins.
// assumes both ends use the same bit time in core_clk cycles.
`timescale 1ns/1ns
module usc_peer (
  input  wire logic core_clk, // clock
  input  wire logic txLine,   // line from block
  output logic      rxLine    // line to block
);
  initial rxLine = 1'b1;
  // start, lsb-first data, stop of chosen level
  task automatic send(input logic [8:0] d, input int nb, input int bt, input logic sv);
    rxLine <= 1'b0;
    repeat (bt) @(posedge core_clk);
    for (int i = 0; i < nb; i++) begin
      rxLine <= d[i];
      repeat (bt) @(posedge core_clk);
    end
    rxLine <= sv;
    repeat (bt) @(posedge core_clk);
    rxLine <= 1'b1;
  endtask : send
  // samples data and stop bit mid-bit
  task automatic recv(input int nb, input int bt, output logic [9:0] d);
    int n = 0;
    d = 10'h000;
    while (txLine !== 1'b0 && n < 5000) begin
      @(posedge core_clk);
      n++;
    end
    repeat (bt / 2) @(posedge core_clk);
    for (int i = 0; i <= nb; i++) begin
      repeat (bt) @(posedge core_clk);
      d[i] = txLine;
    end
  endtask : recv
endmodule : usc_peer

// ### dv/usart_mode_control_status_tb.sv
// usart_mode_control_status_tb: directed scenarios for usc_top.
// assumes the bound checker and an async peer on the pins.
`timescale 1ns/1ns
module usart_mode_control_status_tb;
  import usc_pkg::*;
  logic        core_clk = 1'b0;
  logic        reset    = 1'b1;
  logic        cyc      = 1'b0;
  logic        stb      = 1'b0;
  logic        we       = 1'b0;
  logic [7:0]  adr      = 8'h00;
  logic [31:0] datI     = 32'h0;
  logic [31:0] datO;
  logic        ack, txCkOut, txCkOe, rxDtOut, rxDtOe, irq, peerRx, txPin, rxPin;
  logic [7:0]  rv;
  logic [9:0]  got;
  int          failures  = 0;
  int          nCompared = 0;
  always #5 core_clk = ~core_clk;
  // pads: the enabled party drives, the clock line idles high
  assign txPin = txCkOe ? txCkOut : 1'b1;
  assign rxPin = rxDtOe ? rxDtOut : peerRx;
  usc_top u_dut (.core_clk(core_clk), .reset(reset), .clkEn(1'b1), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(datI), .dat_o(datO),
    .ack_o(ack), .txCkIn(txPin), .txCkOut(txCkOut), .txCkOe(txCkOe), .rxDtIn(rxPin),
    .rxDtOut(rxDtOut), .rxDtOe(rxDtOe), .irq(irq));
  usc_peer u_peer (.core_clk(core_clk), .txLine(txPin), .rxLine(peerRx));
  task automatic cmp(input string nm, input logic [9:0] e, input logic [9:0] s);
    nCompared++;
    if (s !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp
  task automatic cmpB(input string nm, input logic e, input logic s);
    cmp(nm, {9'h0, e}, {9'h0, s});
  endtask : cmpB
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    datI <= {24'h0, d};
    do begin
      @(posedge core_clk);
    end while (ack !== 1'b1);
    rv = datO[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge core_clk);
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb(1'b1, a, d);
  endtask : wr
  task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    cmp(nm, {2'b0, e}, {2'b0, rv});
  endtask : rd
  task automatic waitIrq();
    int n = 0;
    while (irq !== 1'b1 && n < 400) begin
      @(posedge core_clk);
      n++;
    end
    cmpB("irq", 1'b1, irq);
  endtask : waitIrq
  task automatic tReset();
    rd("txscRst", OFS_TXSC, 8'h02);
    rd("rcscRst", OFS_RCSC, 8'h00);
    rd("dirRst", OFS_DIR, 8'hC0);
    rd("unmapped", 8'h40, 8'h00);
    wr(OFS_RCSC, 8'h80);
    wr(OFS_DIR, 8'h40);
    @(posedge core_clk);
    cmpB("oneDir", 1'b0, txCkOe);
    wr(OFS_DIR, 8'hC0);
  endtask : tReset
  task automatic tAsyncTx();
    wr(OFS_BAUD, 8'h01);
    wr(OFS_TXSC, 8'h65);
    wr(OFS_IRQ_EN, 8'h02);
    cmpB("txOe", 1'b1, txCkOe);
    fork
      u_peer.recv(9, 32, got);
      begin
        wr(OFS_TXDATA, 8'hA5);
        rd("busy", OFS_TXSC, 8'h65);
      end
    join
    cmp("txFrame", 10'h3A5, got);
    waitIrq();
    rd("done", OFS_TXSC, 8'h67);
    rd("stat", OFS_IRQ_STAT, 8'h02);
    wr(OFS_IRQ_CLR, 8'h02);
    cmpB("irqClr", 1'b0, irq);
    wr(OFS_TXSC, 8'h04);
    wr(OFS_TXDATA, 8'h55);
    rd("txOff", OFS_TXSC, 8'h06);
    cmpB("idle", 1'b1, txCkOut);
  endtask : tAsyncTx
  task automatic tLowSpeed();
    wr(OFS_BAUD, 8'hFF);
    repeat (40) @(posedge core_clk);
    wr(OFS_BAUD, 8'h00);
    wr(OFS_TXSC, 8'h20);
    fork
      u_peer.recv(8, 64, got);
      wr(OFS_TXDATA, 8'h3C);
    join
    cmp("lowFrame", 10'h13C, got);
    waitIrq();
  endtask : tLowSpeed
  task automatic tDuplex();
    wr(OFS_BAUD, 8'h01);
    wr(OFS_TXSC, 8'h24);
    wr(OFS_RCSC, 8'h90);
    wr(OFS_IRQ_EN, 8'h01);
    fork
      u_peer.send(9'h05A, 8, 32, 1'b1);
      u_peer.recv(8, 32, got);
      wr(OFS_TXDATA, 8'hC3);
    join
    cmp("dupTx", 10'h1C3, got);
    waitIrq();
    rd("dupRx", OFS_RXDATA, 8'h5A);
  endtask : tDuplex
  task automatic tAddr();
    wr(OFS_IRQ_CLR, 8'h0F);
    wr(OFS_RCSC, 8'hD8);
    u_peer.send(9'h012, 9, 32, 1'b1);
    repeat (40) @(posedge core_clk);
    rd("dropped", OFS_IRQ_STAT, 8'h00);
    u_peer.send(9'h1C3, 9, 32, 1'b1);
    waitIrq();
    rd("ninth", OFS_RCSC, 8'hD9);
    rd("addrRx", OFS_RXDATA, 8'hC3);
  endtask : tAddr
  task automatic tErrors();
    wr(OFS_IRQ_CLR, 8'h0F);
    wr(OFS_RCSC, 8'h90);
    wr(OFS_IRQ_EN, 8'h09);
    u_peer.send(9'h011, 8, 32, 1'b0);
    waitIrq();
    rd("ferrSet", OFS_RCSC, 8'h94);
    rd("ferrByte", OFS_RXDATA, 8'h11);
    wr(OFS_IRQ_CLR, 8'h0F);
    u_peer.send(9'h022, 8, 32, 1'b1);
    waitIrq();
    rd("ferrClr", OFS_RCSC, 8'h90);
    wr(OFS_IRQ_CLR, 8'h0F);
    u_peer.send(9'h033, 8, 32, 1'b1);
    waitIrq();
    rd("oerrSet", OFS_RCSC, 8'h92);
    wr(OFS_RCSC, 8'h80);
    rd("oerrClr", OFS_RCSC, 8'h80);
  endtask : tErrors
  task automatic tSync();
    logic [7:0] d;
    logic       p;
    int         k, t0, t1;
    wr(OFS_BAUD, 8'h00);
    wr(OFS_IRQ_CLR, 8'h0F);
    wr(OFS_IRQ_EN, 8'h02);
    wr(OFS_TXSC, 8'hB0);
    wr(OFS_TXDATA, 8'h96);
    k = 0;
    t0 = 0;
    t1 = 0;
    d = 8'h00;
    p = txCkOut;
    // data is taken at each rising edge of the master clock
    for (int n = 0; n < 200 && k < 8; n++) begin
      @(posedge core_clk);
      if (txCkOut && !p) begin
        d[k] = rxDtOut;
        if (k == 0) t0 = n;
        if (k == 1) t1 = n;
        k++;
      end
      p = txCkOut;
    end
    cmp("syncData", {2'b0, 8'h96}, {2'b0, d});
    cmp("syncBit", 10'd4, 10'(t1 - t0));
    waitIrq();
    wr(OFS_RCSC, 8'h90);
    wr(OFS_TXDATA, 8'h77);
    rd("rxWins", OFS_TXSC, 8'hB2);
    cmpB("dtOff", 1'b0, rxDtOe);
    wr(OFS_TXSC, 8'h30);
    @(posedge core_clk);
    cmpB("slaveOe", 1'b0, txCkOe);
    wr(OFS_RCSC, 8'h80);
    wr(OFS_TXSC, 8'hB0);
    rd("lostByte", OFS_RXDATA, 8'h22);
    wr(OFS_RCSC, 8'hA0);
    repeat (60) @(posedge core_clk);
    rd("srenClr", OFS_RCSC, 8'h80);
    rd("syncRx", OFS_RXDATA, 8'hFF);
  endtask : tSync
  task automatic end_of_test();
    $display("compared %0d failures %0d", nCompared, failures);
    if (failures == 0 && nCompared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    tReset();
    tAsyncTx();
    tLowSpeed();
    tDuplex();
    tAddr();
    tErrors();
    tSync();
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    end_of_test();
  end
endmodule : usart_mode_control_status_tb
